// ===== rtl/tmr2_top.sv
// Notes on behaviour
// - Auto-reload runs as internal timer or external event counter per mode select.
// - Down count enable resets to 0; when set, trigger pin sets direction.
// - Up only, trigger disabled: wrap at ffff sets wrap flag and reloads.
// - Up only, trigger enabled: overflow or trigger falling edge reloads; edge sets event flag.
// - Up only mode: interrupt request when wrap or event flag is one.
// - Up/down with trigger high counts up; overflow sets wrap flag, reloads.
// - Up/down with trigger low counts down; at reload value sets wrap, loads ffff.
// - Up/down mode: event flag toggles each wrap, raises no interrupt.
// - Tx and rx rate selects pick this timer or the other timer independently.
// - Baud mode: sixteen-bit rollover at ffff reloads the count from reload value.
// - Serial bit rate is this timer's overflow rate divided by sixteen.
// - Timer increments at clock/12 normally, clock/2 as baud generator or in clock-out mode.
// - Baud mode when either rate select set; rollover sets no flag, no interrupt.
// - Baud mode: trigger falling edge sets event flag without reload.
// - Clock-out gives 50% square wave at clock/(4*(65536-reload)).
// - Clock-out rollovers request no interrupt.
// - Baud generation and clock-out may run together off one overflow rate.
// - Baud generator counts halved clock or event pin edges.
// - Mode select set counts event pin falling edges; clear uses internal clock.
// - Timer counts only while run control is one.
`timescale 1ns/1ps
`include "tmr2_regs.svh"

module tmr2_top
  import tmr2_pkg::*;
(
  input wire logic I_CLOCK,
  input wire logic I_RST_B,
  input wire logic [3:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [3:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY,
  input wire logic I_AUX_TRIGGER_PIN,
  input wire logic I_EVENT_INPUT_PIN,
  input wire logic I_OTHER_TX_TICK,
  input wire logic I_OTHER_RX_TICK,
  output logic O_CLKOUT_PIN,
  output logic O_TX_BIT_TICK,
  output logic O_RX_BIT_TICK,
  output logic O_TIMER_IRQ
);

  logic [1:0] rst_sync_q;
  logic rst_n;
  tmr2_state_t s_q;
  tmr2_state_t s_d;

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // Byte-lane merge of a write into an existing word
  function automatic logic [31:0] merge_w(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Divide a tick stream by sixteen, one output pulse per wrap
  function automatic logic [4:0] div16(input logic [3:0] cnt, input logic tick);
    logic [4:0] r;
    r = {1'b0, cnt};
    if (tick) begin
      r = (cnt == `TMR2_BIT_DIV) ? 5'h10 : {1'b0, cnt + 4'd1};
    end
    return r;
  endfunction

  logic baud_mode;
  logic ev_fall;
  logic trig_fall;
  logic step;
  logic at_top;
  logic at_bottom;
  logic going_up;
  logic wrap;
  logic [3:0] pre_lim;
  logic [4:0] tx_n;
  logic [4:0] rx_n;
  logic [31:0] wd;
  logic wr_fire;
  logic [7:0] ctrl_wr;

  always_comb begin
    s_d = s_q;
    // Synchronisers: first stage feeds only the second
    s_d.sync_ev = {s_q.sync_ev[0], I_EVENT_INPUT_PIN};
    s_d.sync_trig = {s_q.sync_trig[0], I_AUX_TRIGGER_PIN};
    s_d.ev_prev = s_q.sync_ev[1];
    s_d.trig_prev = s_q.sync_trig[1];
    ev_fall = s_q.ev_prev & ~s_q.sync_ev[1];
    trig_fall = s_q.trig_prev & ~s_q.sync_trig[1];

    baud_mode = s_q.ctrl.tx_rate_select | s_q.ctrl.rx_rate_select;
    // Prescaler: clock/2 as baud generator or clock-out, else clock/12
    pre_lim = (baud_mode | s_q.clkout_enable) ? `TMR2_BAUD_DIV : `TMR2_TIMER_DIV;
    step = 1'b0;
    if (s_q.ctrl.run_control) begin
      if (s_q.ctrl.counter_mode_select) begin
        step = ev_fall;
        s_d.pre_cnt = 4'h0;
      end else if (s_q.pre_cnt >= pre_lim - 4'd1) begin
        step = 1'b1;
        s_d.pre_cnt = 4'h0;
      end else begin
        s_d.pre_cnt = s_q.pre_cnt + 4'd1;
      end
    end else begin
      s_d.pre_cnt = 4'h0;
    end

    // Direction only matters in plain up/down auto-reload
    going_up = !(s_q.down_count_enable && !baud_mode && !s_q.clkout_enable) || s_q.sync_trig[1];
    at_top = (s_q.count == `TMR2_ALL_ONES);
    at_bottom = (s_q.count == s_q.reload);
    wrap = step & (going_up ? at_top : at_bottom);

    // Counter, reload happens in place of the wrapping increment
    if (step) begin
      if (wrap) begin
        s_d.count = going_up ? s_q.reload : `TMR2_ALL_ONES;
      end else begin
        s_d.count = going_up ? s_q.count + 16'd1 : s_q.count - 16'd1;
      end
    end
    // Trigger edge reloads only in up-only auto-reload
    if (trig_fall && s_q.ctrl.external_trigger_enable && s_q.ctrl.run_control && !baud_mode && !s_q.down_count_enable && !s_q.clkout_enable) begin
      s_d.count = s_q.reload;
    end

    // Flags; hardware sets win over software clears, applied below
    s_d.tx_div_tick = 1'b0;
    s_d.rx_div_tick = 1'b0;

    // Bus write channel
    s_d.bvalid = s_q.bvalid & ~I_BREADY;
    if (I_AWVALID && !s_q.aw_got && !s_q.bvalid) begin
      s_d.aw_got = 1'b1;
      s_d.aw_addr = I_AWADDR;
    end
    if (I_WVALID && !s_q.w_got && !s_q.bvalid) begin
      s_d.w_got = 1'b1;
      s_d.w_data = I_WDATA;
      s_d.w_strb = I_WSTRB;
    end
    wr_fire = s_q.aw_got & s_q.w_got & ~s_q.bvalid;
    wd = 32'h0;
    ctrl_wr = 8'h0;
    if (wr_fire) begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = `TMR2_RESP_OKAY;
      case (s_q.aw_addr)
        `TMR2_CTRL_ADDR: begin
          wd = merge_w({24'h0, s_q.ctrl}, s_q.w_data, s_q.w_strb);
          ctrl_wr = wd[7:0];
          s_d.ctrl = ctrl_wr;
        end
        `TMR2_MODE_ADDR: begin
          wd = merge_w({30'h0, s_q.clkout_enable, s_q.down_count_enable}, s_q.w_data, s_q.w_strb);
          s_d.clkout_enable = wd[`TMR2_MODE_CKOE];
          s_d.down_count_enable = wd[`TMR2_MODE_DOWN_COUNT_ENABLE];
        end
        `TMR2_COUNT_ADDR: begin
          wd = merge_w({16'h0, s_q.count}, s_q.w_data, s_q.w_strb);
          s_d.count = wd[15:0];
        end
        `TMR2_RELOAD_ADDR: begin
          wd = merge_w({16'h0, s_q.reload}, s_q.w_data, s_q.w_strb);
          s_d.reload = wd[15:0];
        end
        default: begin
          s_d.bresp = `TMR2_RESP_SLVERR;
        end
      endcase
    end

    // Wrap flag: never in baud or clock-out mode
    if (wrap && !baud_mode && !s_q.clkout_enable) begin
      s_d.ctrl.wrap_flag = 1'b1;
    end
    // Event flag: toggles as 17th bit in up/down, else set by trigger edge
    if (s_q.down_count_enable && !baud_mode && !s_q.clkout_enable) begin
      if (wrap) begin
        s_d.ctrl.external_event_flag = ~s_q.ctrl.external_event_flag;
      end
    end else if (trig_fall && s_q.ctrl.external_trigger_enable) begin
      s_d.ctrl.external_event_flag = 1'b1;
    end

    // Clock-out toggles on every wrap, giving 50% duty
    if (!s_q.clkout_enable) begin
      s_d.clkout_pin = 1'b0;
    end else if (wrap) begin
      s_d.clkout_pin = ~s_q.clkout_pin;
    end

    // Bit clocks: timer wraps or the other timer's ticks, either one divided by sixteen
    tx_n = div16(s_q.tx_div, s_q.ctrl.tx_rate_select ? (wrap & baud_mode) : I_OTHER_TX_TICK);
    rx_n = div16(s_q.rx_div, s_q.ctrl.rx_rate_select ? (wrap & baud_mode) : I_OTHER_RX_TICK);
    s_d.tx_div = tx_n[3:0];
    s_d.tx_div_tick = tx_n[4];
    s_d.rx_div = rx_n[3:0];
    s_d.rx_div_tick = rx_n[4];

    // Interrupt: event flag counts only while down count enable is clear, also in baud and clock-out mode
    s_d.irq = s_d.ctrl.wrap_flag | (s_d.ctrl.external_event_flag & ~s_d.down_count_enable);

    // Bus read channel, one word in flight
    case (s_q.rd_state)
      TMR2_RD_IDLE: begin
        if (I_ARVALID) begin
          s_d.rd_state = TMR2_RD_RESP;
          s_d.rresp = `TMR2_RESP_OKAY;
          case (I_ARADDR)
            `TMR2_CTRL_ADDR: s_d.rdata = {24'h0, s_q.ctrl};
            `TMR2_MODE_ADDR: s_d.rdata = {30'h0, s_q.clkout_enable, s_q.down_count_enable};
            `TMR2_COUNT_ADDR: s_d.rdata = {16'h0, s_q.count};
            `TMR2_RELOAD_ADDR: s_d.rdata = {16'h0, s_q.reload};
            default: begin
              s_d.rdata = 32'h0;
              s_d.rresp = `TMR2_RESP_SLVERR;
            end
          endcase
        end
      end
      TMR2_RD_RESP: begin
        if (I_RREADY) begin
          s_d.rd_state = TMR2_RD_IDLE;
        end
      end
      default: begin
        s_d.rd_state = TMR2_RD_IDLE;
      end
    endcase

    // Handshake pins are registered copies of the next state, so no decode gate sits on a pin
    s_d.awready = ~s_d.aw_got & ~s_d.bvalid;
    s_d.wready = ~s_d.w_got & ~s_d.bvalid;
    s_d.arready = (s_d.rd_state == TMR2_RD_IDLE);
    s_d.rvalid = (s_d.rd_state == TMR2_RD_RESP);
  end

  // Single state register; reset holds constants only
  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.ctrl <= `TMR2_CTRL_RST;
      s_q.rd_state <= TMR2_RD_IDLE;
      // Slave is ready for address and data straight out of reset
      s_q.awready <= 1'b1;
      s_q.wready <= 1'b1;
      s_q.arready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign O_AWREADY = s_q.awready;
  assign O_WREADY = s_q.wready;
  assign O_BVALID = s_q.bvalid;
  assign O_BRESP = s_q.bresp;
  assign O_ARREADY = s_q.arready;
  assign O_RVALID = s_q.rvalid;
  assign O_RDATA = s_q.rdata;
  assign O_RRESP = s_q.rresp;
  assign O_CLKOUT_PIN = s_q.clkout_pin;
  assign O_TX_BIT_TICK = s_q.tx_div_tick;
  assign O_RX_BIT_TICK = s_q.rx_div_tick;
  assign O_TIMER_IRQ = s_q.irq;

endmodule

// ===== rtl/tmr2_regs.svh
`ifndef TMR2_REGS_SVH
`define TMR2_REGS_SVH

// Register byte addresses on the AXI4-Lite slave
`define TMR2_CTRL_ADDR 4'h0
`define TMR2_MODE_ADDR 4'h4
`define TMR2_COUNT_ADDR 4'h8
`define TMR2_RELOAD_ADDR 4'hc

// Control register field positions
`define TMR2_CTRL_WRAP 7
`define TMR2_CTRL_EXTF 6
`define TMR2_CTRL_RCLK 5
`define TMR2_CTRL_TX_RATE_SELECT 4
`define TMR2_CTRL_EXEN 3
`define TMR2_CTRL_RUN 2
`define TMR2_CTRL_CNT 1
// Mode register field positions
`define TMR2_MODE_CKOE 1
`define TMR2_MODE_DOWN_COUNT_ENABLE 0

// Reset values and the all-ones count
`define TMR2_CTRL_RST 8'h00
`define TMR2_MODE_RST 2'h0
`define TMR2_ALL_ONES 16'hffff

// Prescale divisors in system clocks
`define TMR2_TIMER_DIV 4'd12
`define TMR2_BAUD_DIV 4'd2
// Bit clock terminal count, dividing by sixteen, for serial modes 1 and 3
`define TMR2_BIT_DIV 4'd15

// AXI responses
`define TMR2_RESP_OKAY 2'h0
`define TMR2_RESP_SLVERR 2'h2

`endif

// ===== rtl/tmr2_pkg.sv
package tmr2_pkg;
  // Control register fields
  typedef struct packed {
    logic wrap_flag;
    logic external_event_flag;
    logic rx_rate_select;
    logic tx_rate_select;
    logic external_trigger_enable;
    logic run_control;
    logic counter_mode_select;
    logic reload_select;
  } tmr2_ctrl_t;

  typedef enum logic [1:0] {
    TMR2_RD_IDLE,
    TMR2_RD_RESP
  } tmr2_rd_state_t;

  typedef struct packed {
    logic [1:0] sync_ev;
    logic [1:0] sync_trig;
    logic ev_prev;
    logic trig_prev;
    tmr2_ctrl_t ctrl;
    logic clkout_enable;
    logic down_count_enable;
    logic [15:0] count;
    logic [15:0] reload;
    logic [3:0] pre_cnt;
    logic clkout_pin;
    logic tx_div_tick;
    logic rx_div_tick;
    logic [3:0] tx_div;
    logic [3:0] rx_div;
    logic irq;
    logic aw_got;
    logic [3:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    tmr2_rd_state_t rd_state;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic awready;
    logic wready;
    logic arready;
    logic rvalid;
  } tmr2_state_t;
endpackage

// ===== verification/tmr2_top_asserts.sv
`timescale 1ns/1ps
module tmr2_top_asserts (
  input wire logic I_CLOCK,
  input wire logic I_RST_B,
  input wire logic O_AWREADY,
  input wire logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic I_ARVALID,
  input wire logic O_ARREADY,
  input wire logic O_RVALID,
  input wire logic I_RREADY,
  input wire logic [31:0] O_RDATA,
  input wire logic O_TX_BIT_TICK,
  input wire logic O_RX_BIT_TICK,
  input wire logic O_CLKOUT_PIN
);
  // One clock domain, so clock and reset are given once
  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (!I_RST_B);
  // Read address accepted by the slave
  sequence s_ar_take;
    I_ARVALID && O_ARREADY;
  endsequence
  property p_b_hold;
    O_BVALID && !I_BREADY |=> O_BVALID;
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("bvalid dropped early");
  property p_r_hold;
    O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer moved");
  property p_aw_block;
    O_BVALID |-> !O_AWREADY;
  endproperty
  a_aw_block: assert property (p_aw_block) else $error("awready with b pending");
  property p_ar_block;
    O_RVALID |-> !O_ARREADY;
  endproperty
  a_ar_block: assert property (p_ar_block) else $error("arready with r pending");
  property p_r_lat;
    s_ar_take |=> O_RVALID;
  endproperty
  a_r_lat: assert property (p_r_lat) else $error("read answer late");
  // Bit ticks come from a divide by sixteen, so they can never sit closer
  property p_tx_pulse;
    O_TX_BIT_TICK |=> !O_TX_BIT_TICK [*8];
  endproperty
  a_tx_pulse: assert property (p_tx_pulse) else $error("tx ticks too close");
  property p_rx_pulse;
    O_RX_BIT_TICK |=> !O_RX_BIT_TICK [*8];
  endproperty
  a_rx_pulse: assert property (p_rx_pulse) else $error("rx ticks too close");
  property p_ck_half;
    $rose(O_CLKOUT_PIN) |=> O_CLKOUT_PIN;
  endproperty
  a_ck_half: assert property (p_ck_half) else $error("clock-out half too short");
endmodule
bind tmr2_top tmr2_top_asserts u_tmr2_top_asserts (.*);

// ===== verification/tmr2_far_model.sv
`timescale 1ns/1ps
module tmr2_far_model (
  input wire logic i_clk,
  input wire logic i_tx_tick,
  input wire logic i_rx_tick,
  input wire logic i_clkout,
  output logic o_other_tx,
  output logic o_other_rx,
  output int o_tx_gap,
  output int o_rx_gap,
  output int o_hi_len
);
  int pt = 0, pr = 0, tc = 0, rc = 0, hc = 0;
  // Other timer ticks at unequal periods so a swapped source is caught
  always @(posedge i_clk) begin
    pt <= (pt == 4) ? 0 : pt + 1;
    pr <= (pr == 6) ? 0 : pr + 1;
    o_other_tx <= (pt == 4);
    o_other_rx <= (pr == 6);
    tc <= i_tx_tick ? 1 : tc + 1;
    rc <= i_rx_tick ? 1 : rc + 1;
    hc <= i_clkout ? hc + 1 : 0;
    if (i_tx_tick) o_tx_gap <= tc; // Serial side sees the bit clock spacing
    if (i_rx_tick) o_rx_gap <= rc;
    if (!i_clkout && hc != 0) o_hi_len <= hc;
  end
endmodule

// ===== verification/tmr2_top_tb_top.sv
`timescale 1ns/1ps
`include "tmr2_regs.svh"
module tmr2_top_tb_top;
  typedef struct packed {
    logic [7:0] c; logic [1:0] m; logic t; logic f; logic [15:0] rl; logic [15:0] cn;
    logic [1:0] fl; logic [15:0] ec; logic [15:0] mk; logic q; int w;
  } tmr2_case_t;
  logic clk = 0, rst_b = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, trig = 1, ev = 1;
  logic [3:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rnd = 32'h28099e8e;
  wire logic awready, wready, bvalid, arready, rvalid, ckout, txt, rxt, irq, otx, orx;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  int tg, rg, hl, fails = 0, check_count = 0, cyc = 0;
  logic [31:0] qv[$], qm[$];
  // Ctrl, mode, trig, fall, reload, count, flags, count seen, mask, irq, wait
  tmr2_case_t tbl [9] = '{
    '{8'h04, 2'd0, 1'b1, 1'b0, 16'hfff0, 16'hfffe, 2'b10, 16'hfff0, 16'hfff0, 1'b1, 60},
    '{8'h04, 2'd1, 1'b0, 1'b0, 16'h1000, 16'h1002, 2'b11, 16'hfff0, 16'hfff0, 1'b1, 60},
    '{8'h04, 2'd1, 1'b1, 1'b0, 16'hfff0, 16'hfffe, 2'b11, 16'hfff0, 16'hfff0, 1'b1, 60},
    '{8'h14, 2'd0, 1'b1, 1'b0, 16'hffff, 16'hfffe, 2'b00, 16'hfff0, 16'hfff0, 1'b0, 200},
    '{8'h0c, 2'd0, 1'b1, 1'b1, 16'h4000, 16'h1000, 2'b01, 16'h4000, 16'hfff0, 1'b1, 60},
    '{8'h1c, 2'd0, 1'b1, 1'b1, 16'h4000, 16'h1000, 2'b01, 16'h1000, 16'hff00, 1'b1, 60},
    '{8'h06, 2'd0, 1'b1, 1'b0, 16'h0000, 16'h0000, 2'b00, 16'h0005, 16'hffff, 1'b0, 60},
    '{8'h00, 2'd0, 1'b1, 1'b0, 16'h0000, 16'h1234, 2'b00, 16'h1234, 16'hffff, 1'b0, 60},
    '{8'h14, 2'd2, 1'b1, 1'b0, 16'hfffc, 16'hfffc, 2'b00, 16'hfff0, 16'hfff0, 1'b0, 400}
  };
  always #12.5 clk = ~clk;
  tmr2_top u_tmr2_top (
    .I_CLOCK(clk), .I_RST_B(rst_b), .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready),
    .I_WDATA(wdata), .I_WSTRB(4'hf), .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp),
    .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready),
    .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready), .I_AUX_TRIGGER_PIN(trig),
    .I_EVENT_INPUT_PIN(ev), .I_OTHER_TX_TICK(otx), .I_OTHER_RX_TICK(orx), .O_CLKOUT_PIN(ckout),
    .O_TX_BIT_TICK(txt), .O_RX_BIT_TICK(rxt), .O_TIMER_IRQ(irq));
  tmr2_far_model u_tmr2_far_model (.i_clk(clk), .i_tx_tick(txt), .i_rx_tick(rxt), .i_clkout(ckout),
    .o_other_tx(otx), .o_other_rx(orx), .o_tx_gap(tg), .o_rx_gap(rg), .o_hi_len(hl));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask
  // Address and data offered together, each released once taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", 32'(bresp), 32'h0);
  endtask
  // The expected word is noted before the read goes out
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    qv.push_back(e);
    qm.push_back(m);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask
  // Read answers are matched against the oldest note
  always @(posedge clk) begin
    if (rvalid === 1'b1 && rready === 1'b1 && qv.size() > 0) begin
      chk("rdata", rdata & qm[0], qv[0]);
      chk("rresp", 32'(rresp), 32'h0);
      void'(qv.pop_front());
      void'(qm.pop_front());
    end
  end
  task report_and_stop;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // A hang ends the run as a failure
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      report_and_stop();
    end
  end
  initial begin
    tmr2_case_t c;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    rd(`TMR2_CTRL_ADDR, 32'h0, 32'hffffffff);
    rd(`TMR2_MODE_ADDR, 32'h0, 32'hffffffff);
    for (int i = 0; i < 9; i++) begin
      c = tbl[i];
      rnd = lfsr(rnd);
      if (i == 7) c.cn = rnd[15:0];
      if (i == 7) c.ec = rnd[15:0];
      trig <= c.t;
      wr(`TMR2_CTRL_ADDR, 32'h0);
      wr(`TMR2_MODE_ADDR, 32'(c.m));
      wr(`TMR2_RELOAD_ADDR, 32'(c.rl));
      wr(`TMR2_COUNT_ADDR, 32'(c.cn));
      wr(`TMR2_CTRL_ADDR, 32'(c.c));
      if (c.f) trig <= 1'b0;
      // Counter mode: five falling edges, each level held longer than the synchroniser delay
      if (c.c[`TMR2_CTRL_CNT]) begin
        repeat (5) begin
          ev <= 1'b0;
          repeat (4) @(posedge clk);
          ev <= 1'b1;
          repeat (4) @(posedge clk);
        end
      end
      repeat (c.w) @(posedge clk);
      #1;
      chk("irq", 32'(irq), 32'(c.q));
      if (i == 3) chk("txgap", tg, 32);
      if (i == 3) chk("rxgap", rg, 112);
      if (i == 8) chk("hilen", hl, 8);
      if (i == 8) chk("txgap", tg, 128);
      rd(`TMR2_CTRL_ADDR, {24'h0, c.fl, 6'h0}, 32'hc0);
      wr(`TMR2_CTRL_ADDR, 32'h0);
      rd(`TMR2_COUNT_ADDR, 32'(c.ec), 32'(c.mk));
    end
    report_and_stop();
  end
endmodule
